// ==== hw/jbs_pkg.sv ====
// constants, instruction codes and state type of the boundary-scan port
package jbs_pkg;
    // instruction register
    localparam int IR_LEN = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_CLAMP = 4'h2;
    localparam logic [3:0] IR_HIGHZ = 4'h3;
    localparam logic [3:0] IR_SAMPLE = 4'h4;
    localparam logic [3:0] IR_IDCODE = 4'he;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // identification register layout
    localparam int ID_LEN = 32;
    localparam int ID_VER_W = 4;
    localparam int ID_PART_W = 16;
    localparam int ID_MAKER_W = 11;
    localparam logic ID_FIXED_BIT = 1'h1;
    // arbitrary neutral identity values
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MAKER = 11'h02a;
    localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER,
                                        ID_FIXED_BIT};

    // boundary chain length: three cells per pin, input only pins one
    localparam int BSR_LEN = 115;

    // synchroniser depth
    localparam int SYNC_LEN = 2;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } jbs_state_type;
endpackage : jbs_pkg

// ==== hw/jbs_bsr.sv ====
// boundary register: capture/shift stage and parallel output latch
`timescale 1ns/10ps
module jbs_bsr #(
    parameter int LEN = 115
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control strobes, one cycle each
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    // serial and parallel data
    input wire logic serial_in,
    input wire logic [LEN-1:0] capture_vec,
    output logic serial_out,
    output logic [LEN-1:0] latch_q
);
    logic [LEN-1:0] stage_q;
    logic [LEN-1:0] stage_d;

    // per-cell next value: capture pin/core value or take upper neighbour
    genvar i;
    generate
        for (i = 0; i < LEN; i++) begin : g_cell
            if (i == LEN - 1) begin : g_top
                assign stage_d[i] = capture_en ? capture_vec[i] :
                                    shift_en ? serial_in : stage_q[i];
            end else begin : g_mid
                assign stage_d[i] = capture_en ? capture_vec[i] :
                                    shift_en ? stage_q[i+1] : stage_q[i];
            end
        end
    endgenerate

    assign serial_out = stage_q[0];

    // shift stage and output latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= '0;
            latch_q <= '0;
        end else begin
            stage_q <= stage_d;
            if (update_en) begin
                latch_q <= stage_q;
            end
        end
    end
endmodule : jbs_bsr

// ==== hw/jbs_tap.sv ====
// test access port controller with instruction, bypass and id registers
//
// Behaviour
// - tap states follow the standard transition graph
// - low test reset holds test logic reset
// - five clocks with mode high reset logic
// - loaded instruction selects the boundary operation
// - code 1111 selects one-bit bypass
// - code 0100 samples pins into boundary chain
// - preload moves shifted data to output latch
// - code 0000 drives pins from output latch
// - captured output cells never reach the pins
// - code 0010 clamps outputs, holds chain, bypass
// - code 0011 floats outputs, holds chain, bypass
// - code 1110 shifts id value out lsb first
// - test-logic-reset loads the id instruction
// - supply, clock, reset, test pins have no cells
// - registers keep contents; test reset gives id
// - every shift starts at the least bit
// - excess output bits equal earlier input bits
// - pulled-up pin may capture one in input cell
// - open-drain pin may capture zero enable cell
// - id register thirty-two bits, four fields
// - id register ignores data shifted in
`timescale 1ns/10ps
module jbs_tap
    import jbs_pkg::*;
#(
    parameter int CHAIN_LEN = BSR_LEN,
    parameter logic [31:0] ID_CODE = ID_VALUE
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // test port pins
    input wire logic test_reset_n,
    input wire logic test_clock_pin,
    input wire logic test_mode_select_pin,
    input wire logic test_data_in_pin,
    output logic test_data_out_pin,
    output logic test_data_out_oe,
    // boundary chain: pin and core values seen at the cells
    input wire logic [CHAIN_LEN-1:0] bsr_capture_vec,
    // boundary chain parallel output latch
    output logic [CHAIN_LEN-1:0] bsr_latch_q,
    // pin control: drive pins from latch, or float all outputs
    output logic pins_from_latch_q,
    output logic pins_highz_q
);
    // synchronisers for pins from the test clock domain
    logic [SYNC_LEN-1:0] tck_s_q;
    logic [SYNC_LEN-1:0] tms_s_q;
    logic [SYNC_LEN-1:0] tdi_s_q;
    logic [SYNC_LEN-1:0] trst_s_q;
    logic tck_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_s_q <= '0;
            tms_s_q <= '1;
            tdi_s_q <= '1;
            trst_s_q <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            tck_s_q <= {tck_s_q[SYNC_LEN-2:0], test_clock_pin};
            tms_s_q <= {tms_s_q[SYNC_LEN-2:0], test_mode_select_pin};
            tdi_s_q <= {tdi_s_q[SYNC_LEN-2:0], test_data_in_pin};
            trst_s_q <= {trst_s_q[SYNC_LEN-2:0], test_reset_n};
            tck_prev_q <= tck_s_q[SYNC_LEN-1];
        end
    end

    // edges and levels of the synchronised pins
    wire tck_lvl = tck_s_q[SYNC_LEN-1];
    wire tck_rise = tck_lvl & ~tck_prev_q;
    wire tck_fall = ~tck_lvl & tck_prev_q;
    wire tms = tms_s_q[SYNC_LEN-1];
    wire tdi = tdi_s_q[SYNC_LEN-1];
    wire trst_active = ~trst_s_q[SYNC_LEN-1];

    // independent count of test clock rises with mode high; even a
    // corrupted state code reaches reset within five such rises
    localparam int RESET_TCKS = 5;
    localparam int HIGH_CNT_W = 3;
    logic [HIGH_CNT_W-1:0] high_cnt_q;
    logic [HIGH_CNT_W-1:0] high_cnt_d;
    wire high_cnt_full = (high_cnt_q == HIGH_CNT_W'(RESET_TCKS - 1));
    wire reset_by_count = tms & high_cnt_full;

    // count saturates at the limit and clears on any low mode sample
    assign high_cnt_d = !tms ? '0 :
                        high_cnt_full ? high_cnt_q :
                        high_cnt_q + 1'b1;

    // count advances with each test clock rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_cnt_q <= '0;
        end else if (trst_active) begin
            high_cnt_q <= '0;
        end else if (tck_rise) begin
            high_cnt_q <= high_cnt_d;
        end
    end

    // tap state register
    jbs_state_type state_q;
    jbs_state_type state_d;

    // next state per the standard graph; five highs reach reset
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    // state advances on each test clock rise; test reset forces reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
        end else if (trst_active) begin
            state_q <= ST_RESET;
        end else if (tck_rise) begin
            state_q <= reset_by_count ? ST_RESET : state_d;
        end
    end

    // state strobes, valid in the cycle of a test clock rise; in_reset and shifting are plain state levels
    wire in_reset = (state_q == ST_RESET);
    wire do_cap_ir = tck_rise & (state_q == ST_CAP_IR);
    wire do_shift_ir = tck_rise & (state_q == ST_SHIFT_IR);
    wire do_upd_ir = tck_rise & (state_q == ST_UPD_IR);
    wire do_cap_dr = tck_rise & (state_q == ST_CAP_DR);
    wire do_shift_dr = tck_rise & (state_q == ST_SHIFT_DR);
    wire do_upd_dr = tck_rise & (state_q == ST_UPD_DR);
    wire shifting = (state_q == ST_SHIFT_IR) | (state_q == ST_SHIFT_DR);

    // instruction shift stage and active instruction
    logic [IR_LEN-1:0] ir_shift_q;
    logic [IR_LEN-1:0] ir_shift_d;
    logic [IR_LEN-1:0] ir_q;
    logic [IR_LEN-1:0] ir_d;

    // reset or test reset forces the id instruction; the shift stage
    // simply holds then, since capture-ir reloads it before any use
    wire ir_force_id = trst_active | in_reset;
    wire [IR_LEN-1:0] ir_shifted = {tdi, ir_shift_q[IR_LEN-1:1]};

    // next shift stage: capture pattern, then one bit per test clock rise
    assign ir_shift_d = ir_force_id ? ir_shift_q :
                        do_cap_ir ? IR_CAPTURE :
                        do_shift_ir ? ir_shifted :
                        ir_shift_q;

    // next instruction: id on reset, shift stage only at update, so a
    // half-shifted code never reaches the decode
    assign ir_d = ir_force_id ? IR_IDCODE :
                  do_upd_ir ? ir_shift_q :
                  ir_q;

    // instruction flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_q <= IR_CAPTURE;
            ir_q <= IR_IDCODE;
        end else begin
            ir_shift_q <= ir_shift_d;
            ir_q <= ir_d;
        end
    end

    // instruction decode; any other code acts as bypass
    wire ir_extest = (ir_q == IR_EXTEST);
    wire ir_sample = (ir_q == IR_SAMPLE);
    wire ir_clamp = (ir_q == IR_CLAMP);
    wire ir_highz = (ir_q == IR_HIGHZ);
    wire ir_idcode = (ir_q == IR_IDCODE);
    wire sel_bsr = ir_extest | ir_sample;
    wire sel_id = ir_idcode;
    wire sel_bypass = ~sel_bsr & ~sel_id;

    // bypass register: captures zero, one cell of delay
    logic bypass_q;
    logic bypass_d;
    wire byp_cap = do_cap_dr & sel_bypass;
    wire byp_shift = do_shift_dr & sel_bypass;

    // next bypass bit: zero on capture, data in on shift
    assign bypass_d = byp_cap ? 1'b0 :
                      byp_shift ? tdi :
                      bypass_q;

    // bypass flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_q <= 1'b0;
        end else begin
            bypass_q <= bypass_d;
        end
    end

    // id register: reloads the fixed code, shifts in only to pass through
    // nothing shifted in survives the next capture
    logic [ID_LEN-1:0] id_shift_q;
    logic [ID_LEN-1:0] id_shift_d;
    wire id_cap = do_cap_dr & sel_id;
    wire id_shift = do_shift_dr & sel_id;
    wire [ID_LEN-1:0] id_shifted = {tdi, id_shift_q[ID_LEN-1:1]};

    // next id stage: fixed code on capture, data in at the top on shift
    assign id_shift_d = id_cap ? ID_CODE :
                        id_shift ? id_shifted :
                        id_shift_q;

    // id flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_shift_q <= ID_CODE;
        end else begin
            id_shift_q <= id_shift_d;
        end
    end

    // boundary chain strobes; clamp and highz leave the chain untouched
    wire bsr_cap = do_cap_dr & sel_bsr;
    wire bsr_shift = do_shift_dr & sel_bsr;
    wire bsr_upd = do_upd_dr & sel_bsr;
    wire bsr_so;

    // chain holds only the pins given to it
    jbs_bsr #(
        .LEN(CHAIN_LEN)
    ) u_bsr (
        .clk(clk),
        .rst_n(rst_n),
        .capture_en(bsr_cap),
        .shift_en(bsr_shift),
        .update_en(bsr_upd),
        .serial_in(tdi),
        .capture_vec(bsr_capture_vec),
        .serial_out(bsr_so),
        .latch_q(bsr_latch_q)
    );

    // serial output select
    wire dr_so = sel_bsr ? bsr_so : sel_id ? id_shift_q[0] : bypass_q;
    wire tdo_next = (state_q == ST_SHIFT_IR) ? ir_shift_q[0] : dr_so;

    // data out changes on the test clock fall, so the tester can take it
    // at the following rise; driven only while shifting, and test reset
    // drops the enable at once without waiting for a fall
    logic tdo_d;
    logic tdo_oe_d;
    wire tdo_load = tck_fall & ~trst_active;

    assign tdo_d = tdo_load ? tdo_next : test_data_out_pin;
    assign tdo_oe_d = trst_active ? 1'b0 :
                      tck_fall ? shifting :
                      test_data_out_oe;

    // data out flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_data_out_pin <= 1'b0;
            test_data_out_oe <= 1'b0;
        end else begin
            test_data_out_pin <= tdo_d;
            test_data_out_oe <= tdo_oe_d;
        end
    end

    // pin control follows the active instruction; the output latch,
    // not the capture stage, feeds the pins, so values captured in
    // capture-dr never reach a pin
    wire pins_from_latch_d = ir_extest | ir_clamp;
    wire pins_highz_d = ir_highz;

    // pin control flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_from_latch_q <= 1'b0;
            pins_highz_q <= 1'b0;
        end else begin
            pins_from_latch_q <= pins_from_latch_d;
            pins_highz_q <= pins_highz_d;
        end
    end
endmodule : jbs_tap

// ==== verif/jbs_host.sv ====
// board tester model: drives the test port pins, samples data out
`timescale 1ns/10ps
module jbs_host (
    // test port pins
    output logic test_reset_n,
    output logic test_clock_pin,
    output logic test_mode_select_pin,
    output logic test_data_in_pin,
    input wire logic test_data_out_pin
);
    // pins idle in reset, clock parked low
    initial begin
        test_reset_n = 1'b0;
        test_clock_pin = 1'b0;
        test_mode_select_pin = 1'b1;
        test_data_in_pin = 1'b1;
    end
    // one 125 ns test clock, far slower than clk
    task automatic tick(input logic m, input logic d, output logic o);
        test_mode_select_pin = m;
        test_data_in_pin = d;
        #62.5 test_clock_pin = 1'b1;
        o = test_data_out_pin;
        #62.5 test_clock_pin = 1'b0;
    endtask : tick
    // test reset low for twenty clocks, released, then idle
    task automatic trst();
        logic o;
        test_reset_n = 1'b0;
        repeat (20) tick(1'b1, 1'b1, o);
        test_reset_n = 1'b1;
        #100 tick(1'b0, 1'b1, o);
    endtask : trst
    // five clocks with mode high, then idle
    task automatic tlr();
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : tlr
    // idle to shift, n bits lsb first, update, idle
    task automatic scan(input logic ir, input int n, input logic [63:0] d,
                        output logic [63:0] q);
        logic o;
        q = '0;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, d[i], o);
            q[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : scan
endmodule : jbs_host

// ==== verif/jbs_tap_chk.sv ====
// concurrent checks on the boundary-scan port pins
`timescale 1ns/10ps
module jbs_tap_chk #(
    parameter int CHAIN_LEN = 115
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // test port pins
    input wire logic test_reset_n,
    input wire logic test_clock_pin,
    input wire logic test_mode_select_pin,
    input wire logic test_data_in_pin,
    input wire logic test_data_out_pin,
    input wire logic test_data_out_oe,
    // boundary chain and pin control
    input wire logic [CHAIN_LEN-1:0] bsr_capture_vec,
    input wire logic [CHAIN_LEN-1:0] bsr_latch_q,
    input wire logic pins_from_latch_q,
    input wire logic pins_highz_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // held test reset: data out off, pin modes back to normal
    hold_reset_a: assert property (
        !test_reset_n [*6] |-> !test_data_out_oe) else $error("oe in reset");
    reset_mode_a: assert property (
        !test_reset_n [*6] |-> !pins_from_latch_q && !pins_highz_q)
        else $error("pin mode kept in reset");
    latch_keep_a: assert property (
        !test_reset_n [*3] |=> $stable(bsr_latch_q)) else $error("latch lost");
    mode_excl_a: assert property (
        !(pins_highz_q && pins_from_latch_q)) else $error("both pin modes");
    highz_hold_a: assert property (
        pins_highz_q && $past(pins_highz_q) |-> $stable(bsr_latch_q))
        else $error("latch moved while floating");
    // outputs move only at the matching test clock edge
    mode_sync_a: assert property (
        $changed({pins_highz_q, pins_from_latch_q}) && test_reset_n
        |-> $past(test_clock_pin, 3)) else $error("mode off tck rise");
    oe_sync_a: assert property (
        $changed(test_data_out_oe) && test_reset_n
        |-> !$past(test_clock_pin, 2)) else $error("oe off tck fall");
    tdo_sync_a: assert property (
        $changed(test_data_out_pin) && test_reset_n
        |-> !$past(test_clock_pin, 2)) else $error("tdo off tck fall");
    // main scenarios reached
    cover property ($rose(pins_highz_q));
    cover property ($rose(pins_from_latch_q));
    cover property ($rose(test_data_out_oe));
endmodule : jbs_tap_chk

bind jbs_tap jbs_tap_chk #(.CHAIN_LEN(CHAIN_LEN)) i_jbs_tap_chk (
    .clk(clk), .rst_n(rst_n), .test_reset_n(test_reset_n),
    .test_clock_pin(test_clock_pin),
    .test_mode_select_pin(test_mode_select_pin),
    .test_data_in_pin(test_data_in_pin),
    .test_data_out_pin(test_data_out_pin),
    .test_data_out_oe(test_data_out_oe), .bsr_capture_vec(bsr_capture_vec),
    .bsr_latch_q(bsr_latch_q), .pins_from_latch_q(pins_from_latch_q),
    .pins_highz_q(pins_highz_q));

// ==== verif/jbs_tap_tb.sv ====
// self-checking bench for the boundary-scan port with a tester model
`timescale 1ns/10ps
module jbs_tap_tb
    import jbs_pkg::*;
;
    localparam int CL = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [CL-1:0] cap = '0;
    wire trst_n, tck, tms, tdi;
    logic tdo, oe, lat_m, hz_m, b;
    logic [CL-1:0] lat;
    logic [63:0] q;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    // tester and design
    jbs_host i_jbs_host (.test_reset_n(trst_n), .test_clock_pin(tck),
        .test_mode_select_pin(tms), .test_data_in_pin(tdi),
        .test_data_out_pin(tdo));
    jbs_tap #(.CHAIN_LEN(CL)) i_jbs_tap (.clk(clk), .rst_n(rst_n),
        .test_reset_n(trst_n), .test_clock_pin(tck),
        .test_mode_select_pin(tms), .test_data_in_pin(tdi),
        .test_data_out_pin(tdo), .test_data_out_oe(oe),
        .bsr_capture_vec(cap), .bsr_latch_q(lat),
        .pins_from_latch_q(lat_m), .pins_highz_q(hz_m));
    task automatic check(input string s, input logic [63:0] g, e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, about six times the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // load an instruction, ir captures 0001
    task automatic ir(input logic [3:0] c);
        i_jbs_host.scan(1'b1, IR_LEN, {60'h0, c}, q);
        check("ir capture", q[3:0], 4'h1);
    endtask : ir
    task automatic t_idcode();
        i_jbs_host.scan(1'b0, 40, 64'ha5, q);
        check("id", q[31:0], ID_VALUE);
        check("id excess", q[39:32], 8'ha5);
        i_jbs_host.scan(1'b0, 32, '0, q);
        check("id kept", q[31:0], ID_VALUE);
        check("oe idle", {63'h0, oe}, 64'h0);
    endtask : t_idcode
    task automatic t_bypass();
        logic [3:0] c [3] = '{IR_BYPASS, 4'h5, 4'hc};
        foreach (c[k]) begin
            ir(c[k]);
            i_jbs_host.scan(1'b0, 8, 64'h96, q);
            check("bypass", q[7:0], 8'h2c);
            check("bypass pins", {lat_m, hz_m}, 2'b00);
        end
    endtask : t_bypass
    // sample then extest: capture pins, preload and update latch
    task automatic t_chain(input logic [3:0] c, input logic [1:0] m,
                           input logic [15:0] v, d);
        ir(c);
        check("chain pins", {lat_m, hz_m}, m);
        @(posedge clk) cap <= v;
        i_jbs_host.scan(1'b0, CL, {48'h0, d}, q);
        check("captured", q[CL-1:0], v);
        check("latch", lat, d);
    endtask : t_chain
    // clamp and float: bypass path, latch held
    task automatic t_hold();
        logic [3:0] c [2] = '{IR_CLAMP, IR_HIGHZ};
        logic [1:0] m [2] = '{2'b10, 2'b01};
        foreach (c[k]) begin
            ir(c[k]);
            check("hold pins", {lat_m, hz_m}, m[k]);
            i_jbs_host.scan(1'b0, 8, 64'h96, q);
            check("hold bypass", q[7:0], 8'h2c);
            check("hold latch", lat, 16'h1234);
        end
    endtask : t_hold
    task automatic t_resets();
        ir(IR_EXTEST);
        i_jbs_host.tlr();
        check("tlr pins", {lat_m, hz_m}, 2'b00);
        i_jbs_host.scan(1'b0, 32, '0, q);
        check("tlr id", q[31:0], ID_VALUE);
        ir(IR_CLAMP);
        // break off an instruction load halfway, then reset and retry
        repeat (2) i_jbs_host.tick(1'b1, 1'b1, b);
        repeat (3) i_jbs_host.tick(1'b0, 1'b0, b);
        i_jbs_host.trst();
        check("trst pins", {lat_m, hz_m}, 2'b00);
        check("trst latch", lat, 16'h1234);
        i_jbs_host.scan(1'b0, 32, '0, q);
        check("trst id", q[31:0], ID_VALUE);
        ir(IR_CLAMP);
        check("retry pins", {lat_m, hz_m}, 2'b10);
    endtask : t_resets
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        i_jbs_host.trst();
        check("reset pins", {lat_m, hz_m}, 2'b00);
        t_idcode();
        t_bypass();
        t_chain(IR_SAMPLE, 2'b00, 16'h3c5a, 16'h9e71);
        t_chain(IR_EXTEST, 2'b10, 16'h0ff0, 16'h1234);
        t_hold();
        t_resets();
        tally_and_finish();
    end
endmodule : jbs_tap_tb
